// ==== logic/swcd_params.svh ====
// Purpose: offsets, fields, reset values of the shadow protect and cacheability decoder
// Assumes: register index n sits at byte address 4*n on the AXI4-Lite bus
// Notes: definitions only
`ifndef SWCD_PARAMS_SVH
`define SWCD_PARAMS_SVH

`define SWCD_IDX_SHADOW1 8'h32
`define SWCD_IDX_DRAM2 8'h35
`define SWCD_IDX_SHADOW3 8'h36
`define SWCD_IDX_ECACHE 8'h37
`define SWCD_IDX_NCW1_SIZE 8'h38
`define SWCD_IDX_NCW1_START 8'h39
`define SWCD_IDX_NCW2_SIZE 8'h3A
`define SWCD_IDX_NCW2_START 8'h3B
`define SWCD_IDX_FEAT2 8'hA1
`define SWCD_IDX_SHADOW2 8'h33
`define SWCD_IDX_STATUS 8'hF0

`define SWCD_RST_SHADOW1 8'hE4
`define SWCD_RST_DRAM2 8'hFF
`define SWCD_RST_SHADOW3 8'h10
`define SWCD_RST_ECACHE 8'h0F
`define SWCD_RST_NCW1_SIZE 8'h80
`define SWCD_RST_NCW1_START 8'h00
`define SWCD_RST_NCW2_SIZE 8'h80
`define SWCD_RST_NCW2_START 8'h00
`define SWCD_RST_FEAT2 8'h00
`define SWCD_RST_SHADOW2 8'h00

`define SWCD_BIT_D_WP 4
`define SWCD_BIT_E_WP 3
`define SWCD_BIT_F_ROM 7
`define SWCD_BIT_C_WP 5
`define SWCD_BIT_F_TEST 1
`define SWCD_BIT_GLOBAL_OFF 1
`define SWCD_BIT_C_NC 0
`define SWCD_BIT_F_NC 2
`define SWCD_BIT_WIN_A24 0
`define SWCD_WIN_SIZE_HI 7
`define SWCD_WIN_SIZE_LO 5

`define SWCD_SZ_64K 3'h0
`define SWCD_SZ_128K 3'h1
`define SWCD_SZ_256K 3'h2
`define SWCD_SZ_1M 3'h3

`define SWCD_RESP_OKAY 2'h0
`define SWCD_RESP_SLVERR 2'h2

`endif

// ==== logic/swcd_pkg.sv ====
// Purpose: types of the shadow protect and cacheability decoder
// Assumes: constants live in swcd_params.svh
// Notes: none
package swcd_pkg;
  typedef enum logic [1:0] {SWCD_DEST_NONE, SWCD_DEST_DRAM, SWCD_DEST_ROM, SWCD_DEST_ISA} swcd_dest_type;
endpackage

// ==== logic/swcd_decoder.sv ====
// Purpose: shadow write protect and L1/L2 cacheability decode with AXI4-Lite config registers
// Assumes: CPU cycle inputs come from logic on clk_in; one AXI access of each kind at a time
// Notes: decision outputs register one cycle after the cycle inputs
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "swcd_params.svh"
`default_nettype none
module swcd_decoder (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  // cpu cycle
  input wire logic cyc_valid_in,
  input wire logic [24:0] cyc_addr_in,
  input wire logic cyc_write_in,
  // decisions
  output logic l1_cacheable_out,
  output logic l2_cacheable_out,
  output logic write_block_out,
  output logic read_from_dram_out,
  output swcd_pkg::swcd_dest_type write_dest_out,
  output logic decision_valid_out,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  import swcd_pkg::*;

  typedef struct packed {
    logic [7:0] shadow1;
    logic [7:0] shadow2;
    logic [7:0] dram2;
    logic [7:0] shadow3;
    logic [7:0] ecache;
    logic [7:0] ncw1_size;
    logic [7:0] ncw1_start;
    logic [7:0] ncw2_size;
    logic [7:0] ncw2_start;
    logic [7:0] feat2;
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic l1;
    logic l2;
    logic wblock;
    logic rdram;
    swcd_dest_type dest;
    logic dvalid;
  } swcd_state_type;

  swcd_state_type st_q;
  swcd_state_type st_d;

  // byte address is four times the register index
  function automatic logic swcd_hit(input logic [11:0] a, input logic [7:0] idx);
    swcd_hit = (a[1:0] == 2'h0) && (a[11:2] == {2'h0, idx});
  endfunction

  function automatic logic swcd_mapped(input logic [11:0] a);
    swcd_mapped = swcd_hit(a, `SWCD_IDX_SHADOW1) || swcd_hit(a, `SWCD_IDX_SHADOW2) ||
      swcd_hit(a, `SWCD_IDX_DRAM2) || swcd_hit(a, `SWCD_IDX_SHADOW3) ||
      swcd_hit(a, `SWCD_IDX_ECACHE) || swcd_hit(a, `SWCD_IDX_NCW1_SIZE) ||
      swcd_hit(a, `SWCD_IDX_NCW1_START) || swcd_hit(a, `SWCD_IDX_NCW2_SIZE) ||
      swcd_hit(a, `SWCD_IDX_NCW2_START) || swcd_hit(a, `SWCD_IDX_FEAT2) ||
      swcd_hit(a, `SWCD_IDX_STATUS);
  endfunction

  // window match on A24..A16, low bits masked by size; size 1xx is off
  function automatic logic swcd_win(input logic [24:0] a, input logic [7:0] sz, input logic [7:0] start);
    logic [8:0] mask;
    logic [2:0] code;
    mask = 9'h1FF;
    code = sz[`SWCD_WIN_SIZE_HI:`SWCD_WIN_SIZE_LO];
    unique case (code)
      `SWCD_SZ_64K: mask = 9'h1FF;
      `SWCD_SZ_128K: mask = 9'h1FE;
      `SWCD_SZ_256K: mask = 9'h1FC;
      `SWCD_SZ_1M: mask = 9'h1F0;
      default: mask = 9'h000;
    endcase
    swcd_win = !code[2] && (((a[24:16] ^ {sz[`SWCD_BIT_WIN_A24], start}) & mask) == 9'h000);
  endfunction

  logic [24:0] a;
  logic in_c0, in_c, in_d, in_e, in_f, shadowed, rd_sel, wp, blk_nc, win_hit, glob_off;
  logic [1:0] e_idx;

  always_comb begin
    st_d = st_q;
    a = cyc_addr_in;
    e_idx = a[15:14];
    in_c = (a[24:16] == 9'h00C);
    in_c0 = in_c && !a[15];
    in_d = (a[24:16] == 9'h00D);
    in_e = (a[24:16] == 9'h00E);
    in_f = (a[24:16] == 9'h00F);
    rd_sel = 1'b0;
    wp = 1'b0;
    blk_nc = 1'b1;
    if (in_c) begin
      rd_sel = st_q.shadow3[a[15:14]];
      wp = st_q.shadow3[`SWCD_BIT_C_WP];
      blk_nc = !in_c0 || st_q.dram2[`SWCD_BIT_C_NC];
    end else if (in_d) begin
      rd_sel = st_q.shadow2[{1'b0, a[15:14]}];
      wp = st_q.shadow1[`SWCD_BIT_D_WP];
    end else if (in_e) begin
      rd_sel = st_q.shadow2[{1'b1, e_idx}];
      wp = st_q.shadow1[`SWCD_BIT_E_WP];
      blk_nc = st_q.ecache[e_idx];
    end else if (in_f) begin
      rd_sel = !st_q.shadow1[`SWCD_BIT_F_ROM];
      wp = rd_sel && !st_q.feat2[`SWCD_BIT_F_TEST];
      blk_nc = st_q.dram2[`SWCD_BIT_F_NC];
    end
    shadowed = rd_sel;
    win_hit = swcd_win(a, st_q.ncw1_size, st_q.ncw1_start) ||
      swcd_win(a, st_q.ncw2_size, st_q.ncw2_start);
    glob_off = st_q.dram2[`SWCD_BIT_GLOBAL_OFF];
    if (clk_en_in) begin
      st_d.dvalid = cyc_valid_in;
      if (cyc_valid_in) begin
        if (in_c || in_d || in_e || in_f) begin
          // l1 needs shadow, enable and writability; l2 tolerates protection on reads
          st_d.l1 = shadowed && !blk_nc && !wp;
          st_d.l2 = shadowed && !blk_nc && (!wp || !cyc_write_in);
          st_d.rdram = !cyc_write_in && shadowed;
          st_d.wblock = cyc_write_in && shadowed && wp;
          if (!cyc_write_in) st_d.dest = shadowed ? SWCD_DEST_DRAM : SWCD_DEST_ROM;
          else if (shadowed && wp) st_d.dest = SWCD_DEST_NONE;
          else st_d.dest = in_f ? SWCD_DEST_ROM : SWCD_DEST_ISA;
        end else begin
          st_d.l1 = 1'b1;
          st_d.l2 = 1'b1;
          st_d.rdram = 1'b1;
          st_d.wblock = 1'b0;
          st_d.dest = SWCD_DEST_DRAM;
        end
        if (glob_off || win_hit) begin
          st_d.l1 = 1'b0;
          st_d.l2 = 1'b0;
        end
      end
      // axi write side
      if (s_axi_awvalid && !st_q.aw_held) begin
        st_d.aw_held = 1'b1;
        st_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_q.w_held) begin
        st_d.w_held = 1'b1;
        st_d.w_data = s_axi_wdata[7:0];
        st_d.w_strb0 = s_axi_wstrb[0];
      end
      if (st_q.aw_held && st_q.w_held && !st_q.bvalid) begin
        st_d.aw_held = 1'b0;
        st_d.w_held = 1'b0;
        st_d.bvalid = 1'b1;
        st_d.bresp = swcd_mapped(st_q.aw_addr) ? `SWCD_RESP_OKAY : `SWCD_RESP_SLVERR;
        if (st_q.w_strb0) begin
          if (swcd_hit(st_q.aw_addr, `SWCD_IDX_SHADOW1)) st_d.shadow1 = st_q.w_data;
          if (swcd_hit(st_q.aw_addr, `SWCD_IDX_SHADOW2)) st_d.shadow2 = st_q.w_data;
          if (swcd_hit(st_q.aw_addr, `SWCD_IDX_DRAM2)) st_d.dram2 = st_q.w_data;
          if (swcd_hit(st_q.aw_addr, `SWCD_IDX_SHADOW3)) st_d.shadow3 = st_q.w_data;
          if (swcd_hit(st_q.aw_addr, `SWCD_IDX_ECACHE)) st_d.ecache = st_q.w_data;
          if (swcd_hit(st_q.aw_addr, `SWCD_IDX_NCW1_SIZE)) st_d.ncw1_size = st_q.w_data;
          if (swcd_hit(st_q.aw_addr, `SWCD_IDX_NCW1_START)) st_d.ncw1_start = st_q.w_data;
          if (swcd_hit(st_q.aw_addr, `SWCD_IDX_NCW2_SIZE)) st_d.ncw2_size = st_q.w_data;
          if (swcd_hit(st_q.aw_addr, `SWCD_IDX_NCW2_START)) st_d.ncw2_start = st_q.w_data;
          if (swcd_hit(st_q.aw_addr, `SWCD_IDX_FEAT2)) st_d.feat2 = st_q.w_data;
        end
      end
      if (st_q.bvalid && s_axi_bready) st_d.bvalid = 1'b0;
      // axi read side; arready is high only while no answer is pending
      if (s_axi_arvalid && !st_q.rvalid) begin
        st_d.rvalid = 1'b1;
        st_d.rresp = swcd_mapped(s_axi_araddr) ? `SWCD_RESP_OKAY : `SWCD_RESP_SLVERR;
        st_d.rdata = 32'h0000_0000;
        if (swcd_hit(s_axi_araddr, `SWCD_IDX_SHADOW1)) st_d.rdata[7:0] = st_q.shadow1;
        if (swcd_hit(s_axi_araddr, `SWCD_IDX_SHADOW2)) st_d.rdata[7:0] = st_q.shadow2;
        if (swcd_hit(s_axi_araddr, `SWCD_IDX_DRAM2)) st_d.rdata[7:0] = st_q.dram2;
        if (swcd_hit(s_axi_araddr, `SWCD_IDX_SHADOW3)) st_d.rdata[7:0] = st_q.shadow3;
        if (swcd_hit(s_axi_araddr, `SWCD_IDX_ECACHE)) st_d.rdata[7:0] = st_q.ecache;
        if (swcd_hit(s_axi_araddr, `SWCD_IDX_NCW1_SIZE)) st_d.rdata[7:0] = st_q.ncw1_size;
        if (swcd_hit(s_axi_araddr, `SWCD_IDX_NCW1_START)) st_d.rdata[7:0] = st_q.ncw1_start;
        if (swcd_hit(s_axi_araddr, `SWCD_IDX_NCW2_SIZE)) st_d.rdata[7:0] = st_q.ncw2_size;
        if (swcd_hit(s_axi_araddr, `SWCD_IDX_NCW2_START)) st_d.rdata[7:0] = st_q.ncw2_start;
        if (swcd_hit(s_axi_araddr, `SWCD_IDX_FEAT2)) st_d.rdata[7:0] = st_q.feat2;
        if (swcd_hit(s_axi_araddr, `SWCD_IDX_STATUS)) begin
          // live view of the last decision
          st_d.rdata[5:0] = {st_q.dvalid, st_q.dest, st_q.rdram, st_q.wblock, st_q.l1 & st_q.l2};
          st_d.rdata[7:6] = {st_q.l2, st_q.l1};
        end
      end
      if (st_q.rvalid && s_axi_rready) st_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= '{shadow1: `SWCD_RST_SHADOW1, shadow2: `SWCD_RST_SHADOW2, dram2: `SWCD_RST_DRAM2,
        shadow3: `SWCD_RST_SHADOW3, ecache: `SWCD_RST_ECACHE, ncw1_size: `SWCD_RST_NCW1_SIZE,
        ncw1_start: `SWCD_RST_NCW1_START, ncw2_size: `SWCD_RST_NCW2_SIZE,
        ncw2_start: `SWCD_RST_NCW2_START, feat2: `SWCD_RST_FEAT2, aw_held: 1'b0, aw_addr: 12'h000,
        w_held: 1'b0, w_data: 8'h00, w_strb0: 1'b0, bvalid: 1'b0, bresp: 2'h0, rvalid: 1'b0,
        rdata: 32'h0000_0000, rresp: 2'h0, l1: 1'b0, l2: 1'b0, wblock: 1'b0, rdram: 1'b0,
        dest: SWCD_DEST_NONE, dvalid: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // ready flags are registered states: held means the channel is not ready
  assign s_axi_awready = !st_q.aw_held;
  assign s_axi_wready = !st_q.w_held;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign l1_cacheable_out = st_q.l1;
  assign l2_cacheable_out = st_q.l2;
  assign write_block_out = st_q.wblock;
  assign read_from_dram_out = st_q.rdram;
  assign write_dest_out = st_q.dest;
  assign decision_valid_out = st_q.dvalid;
endmodule
`default_nettype wire

// ==== bench/swcd_decoder_checker.sv ====
// Purpose: port checks of the shadow protect and cacheability decoder
// Assumes: one clock, async active-low reset
// Notes: register state is hidden here, so checks tie outputs to the cycle kind
`timescale 1ns/1ps
`default_nettype none
module swcd_decoder_checker (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // cpu cycle
  input wire logic clk_en_in,
  input wire logic cyc_valid_in,
  input wire logic [24:0] cyc_addr_in,
  input wire logic cyc_write_in,
  // decisions
  input wire logic l1_cacheable_out,
  input wire logic l2_cacheable_out,
  input wire logic write_block_out,
  input wire logic read_from_dram_out,
  input wire swcd_pkg::swcd_dest_type write_dest_out,
  input wire logic decision_valid_out
);
  import swcd_pkg::*;
  logic tk;
  logic rom;
  assign tk = clk_en_in && cyc_valid_in;
  assign rom = cyc_addr_in[24:18] == 7'h03;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  property p_dv; tk |=> decision_valid_out; endproperty
  a_dv: assert property (p_dv) else $error("no decision after cycle");
  property p_sub; l1_cacheable_out |-> l2_cacheable_out; endproperty
  a_sub: assert property (p_sub) else $error("l1 cacheable but not l2");
  property p_blk; write_block_out |-> write_dest_out == SWCD_DEST_NONE && !l2_cacheable_out; endproperty
  a_blk: assert property (p_blk) else $error("blocked write still routed");
  property p_rdok; tk && !cyc_write_in |=> !write_block_out; endproperty
  a_rdok: assert property (p_rdok) else $error("read blocked");
  property p_out; tk && !rom |=> read_from_dram_out && write_dest_out == SWCD_DEST_DRAM; endproperty
  a_out: assert property (p_out) else $error("plain memory not dram");
  property p_wdst; tk && rom && cyc_write_in |=> write_dest_out != SWCD_DEST_DRAM; endproperty
  a_wdst: assert property (p_wdst) else $error("shadow write sent to dram");
  property p_shd; tk && rom && !cyc_write_in |=> !l2_cacheable_out || read_from_dram_out; endproperty
  a_shd: assert property (p_shd) else $error("unshadowed rom cacheable");
  property p_hold; !tk |=> !decision_valid_out && $stable({l1_cacheable_out, write_dest_out}); endproperty
  a_hold: assert property (p_hold) else $error("decision moved while idle");
  c_blk: cover property (tk ##1 write_block_out);
  c_l1: cover property (decision_valid_out && l1_cacheable_out);
  c_l2: cover property (decision_valid_out && l2_cacheable_out && !l1_cacheable_out);
endmodule
bind swcd_decoder swcd_decoder_checker swcd_decoder_checker_inst (.*);
`default_nettype wire

// ==== bench/swcd_cache_model.sv ====
// Purpose: cache side that takes a line fill per cacheable answer
// Assumes: one fill per decision pulse
// Notes: l1 policy not modelled, write-through and writeback fill alike
`timescale 1ns/1ps
`default_nettype none
module swcd_cache_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // decisions
  input wire logic fill_valid_in,
  input wire logic l1_in,
  input wire logic l2_in,
  // fill counts
  output logic [31:0] l1_fills_out,
  output logic [31:0] l2_fills_out
);
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      l1_fills_out <= 32'h0;
      l2_fills_out <= 32'h0;
    end else if (fill_valid_in) begin
      l1_fills_out <= l1_fills_out + 32'(l1_in);
      l2_fills_out <= l2_fills_out + 32'(l2_in);
    end
  end
endmodule
`default_nettype wire

// ==== bench/test_swcd_decoder.sv ====
// Purpose: random and corner test of the shadow protect and cacheability decoder
// Assumes: byte address is four times the register index
// Notes: clock enable stays high
`timescale 1ns/1ps
`include "swcd_params.svh"
`default_nettype none
module test_swcd_decoder;
  import swcd_pkg::*;
  logic clk_in = 0, resetn_in = 0, clk_en_in = 1, cyc_valid_in = 0, cyc_write_in = 0;
  logic [24:0] cyc_addr_in = 0;
  logic l1_cacheable_out, l2_cacheable_out, write_block_out, read_from_dram_out, decision_valid_out;
  swcd_dest_type write_dest_out;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, m1, m2;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] r [256];
  logic [7:0] ix [10] = '{8'h32, 8'h33, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B, 8'hA1};
  logic [7:0] rv [10] = '{8'hE4, 8'h00, 8'hFF, 8'h10, 8'h0F, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00};
  // corner setups: shadowed with C-E writable and F protected, then a window over all rom space with F unprotected
  logic [7:0] cfg [2][10] = '{'{8'h00, 8'hFF, 8'h00, 8'h0F, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00},
                             '{8'h00, 8'hFF, 8'h00, 8'h0F, 8'h00, 8'h80, 8'h00, 8'h40, 8'h0C, 8'h02}};
  int num_errors = 0, cmp_count = 0, n1 = 0, n2 = 0;
  initial forever #10 clk_in = ~clk_in;
  swcd_decoder swcd_decoder_inst (.*);
  swcd_cache_model swcd_cache_model_inst (.clk_in(clk_in), .resetn_in(resetn_in), .fill_valid_in(decision_valid_out),
    .l1_in(l1_cacheable_out), .l2_in(l2_cacheable_out), .l1_fills_out(m1), .l2_fills_out(m2));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d, input logic [3:0] st,
                     output logic [31:0] dt, output logic [1:0] rs);
    @(posedge clk_in);
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_araddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= {24'($urandom()), d};
    s_axi_wstrb <= st;
    s_axi_bready <= w;
    s_axi_rready <= !w;
    do begin
      @(posedge clk_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(w ? s_axi_bvalid : s_axi_rvalid));
    dt = s_axi_rdata;
    rs = w ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  // k masks fields left open: write-side read source, routing of unshadowed protected blocks
  function automatic logic [5:0] exp_dec(input logic [24:0] a, input logic w, output logic [5:0] k);
    logic [1:0] b, s;
    logic [7:0] z;
    logic [8:0] mk;
    logic sh, wp, nc, on, in;
    b = a[17:16];
    s = a[15:14];
    in = a[24:18] == 7'h03;
    on = !r[8'h35][1];
    for (int n = 0; n < 4; n += 2) begin
      z = r[8'h38 + n];
      mk = 9'h1FF << (z[6:5] == 2'h3 ? 3'h4 : {1'b0, z[6:5]});
      if (!z[7] && ((a[24:16] ^ {z[0], r[8'h39 + n]}) & mk) == 9'h0) on = 1'b0;
    end
    sh = b == 0 ? r[8'h36][s] : b == 1 ? r[8'h33][s] : b == 2 ? r[8'h33][4 + s] : !r[8'h32][7];
    wp = b == 0 ? r[8'h36][5] : b == 1 ? r[8'h32][4] : b == 2 ? r[8'h32][3] : sh && !r[8'hA1][1];
    nc = b == 0 ? s[1] || r[8'h35][0] : b == 1 ? 1'b1 : b == 2 ? r[8'h37][s] : r[8'h35][2];
    k = in && w ? (sh || !wp ? 6'h3B : 6'h30) : 6'h3F;
    if (!in) return {on, on, 2'h1, SWCD_DEST_DRAM};
    return {on && sh && !nc && !wp, on && sh && !nc && (!wp || !w), w && wp, sh,
            w ? (wp ? SWCD_DEST_NONE : b == 3 ? SWCD_DEST_ROM : SWCD_DEST_ISA) : sh ? SWCD_DEST_DRAM : SWCD_DEST_ROM};
  endfunction
  task automatic cyc(input logic [24:0] a, input logic w);
    logic [5:0] e, k;
    e = exp_dec(a, w, k);
    n1 += e[5];
    n2 += e[4];
    @(posedge clk_in);
    cyc_valid_in <= 1'b1;
    cyc_addr_in <= a;
    cyc_write_in <= w;
    @(posedge clk_in);
    cyc_valid_in <= 1'b0;
    #1;
    chk("decision", 32'(e & k), 32'({l1_cacheable_out, l2_cacheable_out, write_block_out, read_from_dram_out,
        write_dest_out} & k));
    chk("decision valid", 32'h1, 32'(decision_valid_out));
  endtask
  initial begin
    logic [31:0] dt;
    logic [1:0] rs;
    logic [7:0] d;
    void'($urandom(32'h9287f107));
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    foreach (ix[j]) begin
      bus(0, ix[j], 8'h00, 4'h0, dt, rs);
      chk("reset value", {24'h0, rv[j]}, dt);
      r[ix[j]] = rv[j];
    end
    bus(1, 8'h40, 8'h5A, 4'hF, dt, rs);
    chk("unmapped bresp", 32'(`SWCD_RESP_SLVERR), 32'(rs));
    bus(0, 8'h40, 8'h00, 4'h0, dt, rs);
    chk("unmapped rresp", 32'(`SWCD_RESP_SLVERR), 32'(rs));
    bus(1, 8'h35, 8'h00, 4'h0, dt, rs);
    bus(0, 8'h35, 8'h00, 4'h0, dt, rs);
    chk("strobe off", 32'hFF, dt);
    for (int c = 0; c < 8; c++) begin
      foreach (ix[j]) begin
        d = c < 2 ? cfg[c][j] : 8'($urandom());
        bus(1, ix[j], d, 4'hF, dt, rs);
        r[ix[j]] = d;
        bus(0, ix[j], 8'h00, 4'h0, dt, rs);
        chk("readback", {24'h0, d}, dt);
      end
      repeat (24) cyc($urandom() % 4 ? {7'h03, 18'($urandom())} : 25'($urandom()), 1'($urandom()));
    end
    @(posedge clk_in);
    #1;
    chk("l1 fills", n1, m1);
    chk("l2 fills", n2, m2);
    end_sim();
  end
  initial begin
    #400000;
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
